// ### core/rss_pkg.sv
package rss_pkg;

  // Register map (word indices on the plain register port)
  localparam logic [3:0] RSS_REG_CTRL     = 4'h0;
  localparam logic [3:0] RSS_REG_COUNT    = 4'h1;
  localparam logic [3:0] RSS_REG_TRIG     = 4'h2;
  localparam logic [3:0] RSS_REG_MON      = 4'h3;
  localparam logic [3:0] RSS_REG_STATUS   = 4'h4;
  localparam logic [3:0] RSS_REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] RSS_REG_IRQ_MASK = 4'h6;
  localparam logic [3:0] RSS_REG_LIST_LEN = 4'h7;
  localparam logic [3:0] RSS_REG_LIST_ENT = 4'h8;
  localparam logic [3:0] RSS_REG_CLOSED   = 4'h9;

  // CTRL write bits (action bits are pulses, not stored)
  localparam int RSS_CTRL_CONT_BIT  = 0;
  localparam int RSS_CTRL_START_BIT = 1;
  localparam int RSS_CTRL_ABORT_BIT = 2;
  localparam int RSS_CTRL_CLEAR_BIT = 3;
  localparam int RSS_CTRL_MON_BIT   = 4;

  // COUNT write: bit 16 min, bit 17 max select on read-back and write
  localparam int RSS_CNT_MIN_BIT = 16;
  localparam int RSS_CNT_MAX_BIT = 17;
  localparam logic [14:0] RSS_CNT_MIN   = 15'h0001;
  localparam logic [14:0] RSS_CNT_MAX   = 15'h7FFF;
  localparam logic [14:0] RSS_CNT_RESET = 15'h0001;

  // Interrupt bits
  localparam int RSS_IRQ_DONE_BIT = 0;
  localparam int RSS_IRQ_ERR_BIT  = 1;
  localparam int RSS_IRQ_STEP_BIT = 2;
  localparam int RSS_IRQ_W        = 3;

  localparam logic [6:0] RSS_MON_AUTO = 7'h00;

  typedef enum logic [2:0] {
    RSS_SRC_IMM,
    RSS_SRC_BUS,
    RSS_SRC_HOLD,
    RSS_SRC_EXT
  } rss_src_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rss_bus_t;

endpackage

// ### core/rss_sequencer.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int LIST_DEPTH = 64,
  parameter int CHAN_W     = 5
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Register port
  input  wire rss_bus_t             bus,
  output logic [31:0]               rdata_ff,
  // Trigger inputs from outside
  input  wire logic                 bus_trig,
  input  wire logic                 ext_trig,
  // Last card addressed by a switching command
  input  wire logic [6:0]           last_card,
  // Relay drive and status
  output logic [31:0]               relay_ff,
  output logic                      scanning_ff,
  output logic [6:0]                mon_card_ff,
  output logic                      irq_ff
);

  localparam int IDX_W = $clog2(LIST_DEPTH);

  typedef enum logic [1:0] {
    RSS_IDLE,
    RSS_RUN
  } rss_state_t;

  rss_state_t        state_ff;
  logic [11:0]       list_ff [LIST_DEPTH];
  logic [IDX_W:0]    len_ff;
  logic              list_valid_ff;
  logic [IDX_W-1:0]  pos_ff;
  logic [14:0]       count_ff;
  logic [14:0]       cyc_ff;
  logic              cont_ff;
  logic              mon_en_ff;
  logic [6:0]        mon_sel_ff;
  rss_src_t          src_ff;
  logic [RSS_IRQ_W-1:0] irq_stat_ff;
  logic [RSS_IRQ_W-1:0] irq_mask_ff;
  logic [2:0]        ext_sync_ff;
  logic [1:0]        bus_sync_ff;

  logic wr_ctrl;
  logic start_req;
  logic abort_req;
  logic clear_req;
  logic trig;
  logic at_last;
  logic last_cycle;
  logic ev_done;
  logic ev_err;
  logic ev_step;
  logic [11:0] cur_ent;
  logic [11:0] first_ent;
  logic [IDX_W-1:0] last_pos;

  assign wr_ctrl   = bus.wr && (bus.addr == RSS_REG_CTRL);
  assign start_req = wr_ctrl && bus.wdata[RSS_CTRL_START_BIT];
  assign abort_req = wr_ctrl && bus.wdata[RSS_CTRL_ABORT_BIT];
  assign clear_req = wr_ctrl && bus.wdata[RSS_CTRL_CLEAR_BIT];
  assign cur_ent   = list_ff[pos_ff];
  assign first_ent = list_ff[0];
  assign last_pos  = IDX_W'(len_ff - 1'b1);
  assign at_last   = (pos_ff == last_pos);
  assign last_cycle = (cyc_ff == count_ff);

  // External triggers: two synchroniser flops each, plus a third flop on ext; edge detect on the synchronised ext copy only, bus trigger is used as a level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_sync_ff <= 3'h0;
      bus_sync_ff <= 2'h0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_trig};
      bus_sync_ff <= {bus_sync_ff[0], bus_trig};
    end
  end

  // Trigger source select; immediate fires every cycle
  always_comb begin
    case (src_ff)
      RSS_SRC_IMM:  trig = 1'b1;
      RSS_SRC_BUS:  trig = bus_sync_ff[1];
      RSS_SRC_EXT:  trig = ext_sync_ff[1] && !ext_sync_ff[2];
      RSS_SRC_HOLD: trig = 1'b0;
      default:      trig = 1'b0;
    endcase
  end

  // Abort applies only under bus or hold triggering
  logic abort_ok;
  assign abort_ok = abort_req && (src_ff == RSS_SRC_BUS || src_ff == RSS_SRC_HOLD);

  assign ev_err  = start_req && !list_valid_ff;
  assign ev_step = (state_ff == RSS_RUN) && trig && !abort_ok && !clear_req;
  assign ev_done = ev_step && at_last && !cont_ff && last_cycle;

  // Scan sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff    <= RSS_IDLE;
      pos_ff      <= '0;
      cyc_ff      <= 15'h0001;
      relay_ff    <= 32'h0;
      scanning_ff <= 1'b0;
    end else if (state_ff == RSS_RUN && (abort_ok || clear_req)) begin
      state_ff    <= RSS_IDLE;
      scanning_ff <= 1'b0;
      relay_ff    <= 32'h0;
    end else begin
      case (state_ff)
        RSS_IDLE: begin
          if (start_req && list_valid_ff) begin
            state_ff    <= RSS_RUN;
            scanning_ff <= 1'b1;
            pos_ff      <= '0;
            cyc_ff      <= 15'h0001;
            relay_ff    <= 32'h1 << first_ent[CHAN_W-1:0];
          end
        end
        RSS_RUN: begin
          if (ev_step) begin
            if (!at_last) begin
              pos_ff   <= pos_ff + 1'b1;
              relay_ff <= 32'h1 << list_ff[pos_ff + 1'b1][CHAN_W-1:0];
            end else if (cont_ff || !last_cycle) begin
              pos_ff   <= '0;
              relay_ff <= 32'h1 << first_ent[CHAN_W-1:0];
              if (!cont_ff) begin
                cyc_ff <= cyc_ff + 1'b1;
              end
            end else begin
              relay_ff    <= 32'h0;
              state_ff    <= RSS_IDLE;
              scanning_ff <= 1'b0;
            end
          end
        end
        default: state_ff <= RSS_IDLE;
      endcase
    end
  end

  // Channel list: writing length starts a new definition, abort invalidates it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      len_ff        <= '0;
      list_valid_ff <= 1'b0;
    end else if (abort_ok) begin
      list_valid_ff <= 1'b0;
    end else if (bus.wr && bus.addr == RSS_REG_LIST_LEN && state_ff == RSS_IDLE) begin
      len_ff        <= bus.wdata[IDX_W:0];
      list_valid_ff <= (bus.wdata[IDX_W:0] != '0)
                       && (bus.wdata[IDX_W:0] <= (IDX_W+1)'(LIST_DEPTH));
    end
  end

  // Entry write: bits [21:16] index, [11:0] card*100+channel coded as card/chan
  always_ff @(posedge clock) begin
    if (bus.wr && bus.addr == RSS_REG_LIST_ENT && state_ff == RSS_IDLE) begin
      list_ff[bus.wdata[16+IDX_W-1:16]] <= bus.wdata[11:0];
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_ff   <= RSS_CNT_RESET;
      cont_ff    <= 1'b0;
      mon_en_ff  <= 1'b0;
      mon_sel_ff <= RSS_MON_AUTO;
      src_ff     <= RSS_SRC_IMM;
    end else if (bus.wr) begin
      case (bus.addr)
        RSS_REG_CTRL: begin
          cont_ff   <= bus.wdata[RSS_CTRL_CONT_BIT];
          mon_en_ff <= bus.wdata[RSS_CTRL_MON_BIT];
        end
        RSS_REG_COUNT: begin
          if (bus.wdata[RSS_CNT_MIN_BIT]) begin
            count_ff <= RSS_CNT_MIN;
          end else if (bus.wdata[RSS_CNT_MAX_BIT]) begin
            count_ff <= RSS_CNT_MAX;
          end else if (bus.wdata[14:0] != 15'h0) begin
            count_ff <= bus.wdata[14:0];
          end
        end
        RSS_REG_TRIG: src_ff <= rss_src_t'(bus.wdata[2:0]);
        RSS_REG_MON: begin
          if (bus.wdata[6:0] <= 7'h63) begin
            mon_sel_ff <= bus.wdata[6:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Monitored card: automatic follows the last switching command
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mon_card_ff <= RSS_MON_AUTO;
    end else begin
      mon_card_ff <= (mon_sel_ff == RSS_MON_AUTO) ? last_card : mon_sel_ff;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  logic [RSS_IRQ_W-1:0] ev_vec;
  assign ev_vec = {ev_step, ev_err, ev_done};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == RSS_REG_IRQ_MASK) begin
        irq_mask_ff <= bus.wdata[RSS_IRQ_W-1:0];
      end
      if (bus.wr && bus.addr == RSS_REG_IRQ_STAT) begin
        irq_stat_ff <= (irq_stat_ff & ~bus.wdata[RSS_IRQ_W-1:0]) | ev_vec;
      end else begin
        irq_stat_ff <= irq_stat_ff | ev_vec;
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0;
    end else if (bus.rd) begin
      case (bus.addr)
        RSS_REG_CTRL: rdata_ff <= {27'h0, mon_en_ff, 3'h0, cont_ff};
        RSS_REG_COUNT: begin
          if (bus.wdata[RSS_CNT_MIN_BIT]) begin
            rdata_ff <= {17'h0, RSS_CNT_MIN};
          end else if (bus.wdata[RSS_CNT_MAX_BIT]) begin
            rdata_ff <= {17'h0, RSS_CNT_MAX};
          end else begin
            rdata_ff <= {17'h0, count_ff};
          end
        end
        RSS_REG_TRIG:     rdata_ff <= {29'h0, src_ff};
        RSS_REG_MON:      rdata_ff <= {25'h0, mon_sel_ff};
        RSS_REG_STATUS:   rdata_ff <= {list_valid_ff, 15'h0, 1'b0, cyc_ff[14:0]} |
                                      {31'h0, scanning_ff};
        RSS_REG_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
        RSS_REG_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        RSS_REG_LIST_LEN: rdata_ff <= {{(31-IDX_W){1'b0}}, len_ff};
        RSS_REG_CLOSED:   rdata_ff <= mon_en_ff ? relay_ff : 32'h0;
        default:          rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  a_start_closes_first: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == RSS_IDLE && start_req && list_valid_ff) |=> (scanning_ff && relay_ff != 32'h0))
    else $error("start did not close first channel");

  a_bad_start_idle: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == RSS_IDLE && start_req && !list_valid_ff)
    |=> (!scanning_ff && irq_stat_ff[RSS_IRQ_ERR_BIT]))
    else $error("start on invalid list ran or missed error");

  a_abort_invalid: assert property (@(posedge clock) disable iff (!nrst)
    abort_ok |=> (!list_valid_ff && !scanning_ff))
    else $error("abort left scan or list valid");

  a_abort_ignored: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == RSS_RUN && abort_req && !abort_ok && !clear_req && !ev_done) |=> scanning_ff)
    else $error("abort stopped scan under other trigger source");

  a_clear_stops: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == RSS_RUN && clear_req) |=> (!scanning_ff && relay_ff == 32'h0))
    else $error("clear did not stop scan");

  a_done_opens: assert property (@(posedge clock) disable iff (!nrst)
    ev_done |=> (relay_ff == 32'h0 && state_ff == RSS_IDLE))
    else $error("end of scan left relay closed");

  a_cont_wraps: assert property (@(posedge clock) disable iff (!nrst)
    (ev_step && at_last && cont_ff) |=> (scanning_ff && pos_ff == '0))
    else $error("continuous scan did not wrap");

  a_idle_holds: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == RSS_IDLE && !start_req) |=> $stable(relay_ff))
    else $error("relays moved while idle");

  a_step_advances: assert property (@(posedge clock) disable iff (!nrst)
    (ev_step && !at_last) |=> (pos_ff == IDX_W'($past(pos_ff) + 1'b1)))
    else $error("trigger did not advance one entry");

  a_one_closed: assert property (@(posedge clock) disable iff (!nrst)
    scanning_ff |-> $onehot(relay_ff))
    else $error("scan does not hold exactly one channel closed");

  a_mon_auto: assert property (@(posedge clock) disable iff (!nrst)
    (mon_sel_ff == RSS_MON_AUTO) |=> (mon_card_ff == $past(last_card)))
    else $error("automatic monitor did not follow last card");

  a_mon_fixed: assert property (@(posedge clock) disable iff (!nrst)
    (mon_sel_ff != RSS_MON_AUTO) |=> (mon_card_ff == $past(mon_sel_ff)))
    else $error("monitor did not show selected card");

  a_closed_hidden: assert property (@(posedge clock) disable iff (!nrst)
    (bus.rd && bus.addr == RSS_REG_CLOSED && !mon_en_ff) |=> (rdata_ff == 32'h0))
    else $error("closed map shown with monitor off");

  a_count_min_read: assert property (@(posedge clock) disable iff (!nrst)
    (bus.rd && bus.addr == RSS_REG_COUNT && bus.wdata[RSS_CNT_MIN_BIT])
    |=> (rdata_ff == {17'h0, RSS_CNT_MIN}))
    else $error("count minimum read wrong");

  a_count_max_read: assert property (@(posedge clock) disable iff (!nrst)
    (bus.rd && bus.addr == RSS_REG_COUNT && !bus.wdata[RSS_CNT_MIN_BIT]
     && bus.wdata[RSS_CNT_MAX_BIT])
    |=> (rdata_ff == {17'h0, RSS_CNT_MAX}))
    else $error("count maximum read wrong");

  a_cont_readback: assert property (@(posedge clock) disable iff (!nrst)
    (bus.rd && bus.addr == RSS_REG_CTRL) |=> (rdata_ff[RSS_CTRL_CONT_BIT] == $past(cont_ff)))
    else $error("continuous setting read wrong");

  a_count_zero_kept: assert property (@(posedge clock) disable iff (!nrst)
    (bus.wr && bus.addr == RSS_REG_COUNT && bus.wdata[RSS_CNT_MAX_BIT:0] == '0)
    |=> $stable(count_ff))
    else $error("zero cycle count was taken");

endmodule

// ### tb/rss_host_model.sv
`timescale 1ns/1ps
module rss_host_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Trigger lines towards the sequencer
  output logic      bus_trig,
  output logic      ext_trig
);
  initial begin
    bus_trig = 1'b0;
    ext_trig = 1'b0;
  end

  // One high cycle is one trigger; gap models a slow host
  task automatic fire_bus(input int gap);
    wait (nrst);
    repeat (gap + 1) @(posedge clock);
    bus_trig <= 1'b1;
    @(posedge clock);
    bus_trig <= 1'b0;
  endtask

  // Held high long enough to cross the input synchroniser
  task automatic fire_ext(input int gap);
    wait (nrst);
    repeat (gap + 1) @(posedge clock);
    ext_trig <= 1'b1;
    repeat (4) @(posedge clock);
    ext_trig <= 1'b0;
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import rss_pkg::*;
  logic        clock, nrst, bus_trig, ext_trig, irq_ff, scanning_ff, rd_d;
  rss_bus_t    bus;
  logic [31:0] rdata_ff, relay_ff, relay_prev;
  logic [6:0]  last_card, mon_card_ff;
  logic [31:0] rq[$];
  logic [31:0] rdq[$];
  logic [4:0]  ch[3];
  int          error_cnt, total_checks, seed, n, card;

  rss_sequencer dut_u (.clock(clock), .nrst(nrst), .bus(bus), .rdata_ff(rdata_ff),
    .bus_trig(bus_trig), .ext_trig(ext_trig), .last_card(last_card), .relay_ff(relay_ff),
    .scanning_ff(scanning_ff), .mon_card_ff(mon_card_ff), .irq_ff(irq_ff));
  rss_host_model host_u (.clock(clock), .nrst(nrst), .bus_trig(bus_trig),
    .ext_trig(ext_trig));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data and every relay change are matched against the oldest note
  always @(posedge clock) begin
    if (rd_d) check(rdata_ff, rdq.size() ? rdq.pop_front() : 32'hFFFF_FFFF);
    if (relay_ff !== relay_prev) check(relay_ff, rq.size() ? rq.pop_front() : 32'hFFFF_FFFF);
    rd_d <= bus.rd;
    relay_prev <= relay_ff;
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '{4'h0, 32'h0, 1'b0, 1'b0};
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    rdq.push_back(exp);
    bus <= '{a, d, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '{4'h0, 32'h0, 1'b0, 1'b0};
    @(posedge clock);
  endtask

  // Wait until every noted relay change has been seen
  task automatic settle();
    for (int i = 0; i < 400 && rq.size() != 0; i++) @(posedge clock);
    check(32'(rq.size()), 32'h0);
    repeat (2) @(posedge clock);
  endtask

  // Three distinct channels so every step shows as a relay change
  task automatic load_list();
    ch[0] = 5'($random(seed));
    ch[1] = ch[0] + 5'h07;
    ch[2] = ch[0] + 5'h0D;
    wr(RSS_REG_LIST_LEN, 32'h3);
    for (int i = 0; i < 3; i++) wr(RSS_REG_LIST_ENT, {9'h0, 7'(i), 11'h0, ch[i]});
  endtask

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  initial begin
    seed = 16347;
    error_cnt = 0;
    total_checks = 0;
    nrst = 1'b0;
    rd_d = 1'b0;
    relay_prev = 32'h0;
    last_card = 7'h05;
    bus = '{4'h0, 32'h0, 1'b0, 1'b0};
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    last_card <= 7'($unsigned($random(seed)) % 99 + 1);
    @(posedge clock);
    rd(RSS_REG_COUNT, 32'h0, 32'h1);
    rd(RSS_REG_CTRL, 32'h0, 32'h0);
    rd(RSS_REG_TRIG, 32'h0, 32'h0);
    rd(RSS_REG_MON, 32'h0, 32'h0);
    rd(RSS_REG_CLOSED, 32'h0, 32'h0);
    rd(RSS_REG_STATUS, 32'h0, 32'h1);
    rd(4'hF, 32'h0, 32'h0);
    check({25'h0, mon_card_ff}, {25'h0, last_card});
    last_card <= 7'($unsigned($random(seed)) % 99 + 1);
    repeat (3) @(posedge clock);
    check({25'h0, mon_card_ff}, {25'h0, last_card});
    // Start with no list defined
    wr(RSS_REG_IRQ_MASK, 32'h2);
    wr(RSS_REG_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    check({31'h0, irq_ff}, 32'h1);
    check({31'h0, scanning_ff}, 32'h0);
    rd(RSS_REG_IRQ_STAT, 32'h0, 32'h2);
    wr(RSS_REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clock);
    check({31'h0, irq_ff}, 32'h0);
    // Cycle count limits
    rd(RSS_REG_COUNT, 32'h1_0000, 32'h1);
    rd(RSS_REG_COUNT, 32'h2_0000, 32'h7FFF);
    wr(RSS_REG_COUNT, 32'h0);
    rd(RSS_REG_COUNT, 32'h0, 32'h1);
    wr(RSS_REG_COUNT, 32'h2_0000);
    rd(RSS_REG_COUNT, 32'h0, 32'h7FFF);
    n = $unsigned($random(seed)) % 3 + 2;
    wr(RSS_REG_COUNT, 32'(n));
    rd(RSS_REG_COUNT, 32'h0, 32'(n));
    // Immediate source, n passes, then idle
    load_list();
    wr(RSS_REG_IRQ_MASK, 32'h1);
    for (int r = 0; r < n; r++)
      for (int i = 0; i < 3; i++) rq.push_back(32'h1 << ch[i]);
    rq.push_back(32'h0);
    wr(RSS_REG_CTRL, 32'h2);
    settle();
    check({31'h0, scanning_ff}, 32'h0);
    check({31'h0, irq_ff}, 32'h1);
    rd(RSS_REG_IRQ_STAT, 32'h0, 32'h5);
    repeat (20) @(posedge clock);
    // Bus source, continuous, wrap, then abort
    wr(RSS_REG_IRQ_STAT, 32'h7);
    wr(RSS_REG_TRIG, 32'h1);
    wr(RSS_REG_CTRL, 32'h1);
    rd(RSS_REG_CTRL, 32'h0, 32'h1);
    rq.push_back(32'h1 << ch[0]);
    wr(RSS_REG_CTRL, 32'h3);
    settle();
    for (int i = 1; i < 5; i++) begin
      rq.push_back(32'h1 << ch[i % 3]);
      host_u.fire_bus(i % 2 * 6);
      settle();
    end
    rq.push_back(32'h0);
    wr(RSS_REG_CTRL, 32'h5);
    settle();
    check({31'h0, scanning_ff}, 32'h0);
    wr(RSS_REG_IRQ_STAT, 32'h7);
    wr(RSS_REG_IRQ_MASK, 32'h2);
    wr(RSS_REG_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    check({31'h0, irq_ff}, 32'h1);
    wr(RSS_REG_IRQ_STAT, 32'h7);
    // Hold source with monitor on, abort stops it
    load_list();
    wr(RSS_REG_TRIG, 32'h2);
    card = $unsigned($random(seed)) % 99 + 1;
    wr(RSS_REG_MON, 32'(card));
    wr(RSS_REG_MON, 32'h64);
    rd(RSS_REG_MON, 32'h0, 32'(card));
    check({25'h0, mon_card_ff}, 32'(card));
    rq.push_back(32'h1 << ch[0]);
    wr(RSS_REG_CTRL, 32'h12);
    settle();
    host_u.fire_bus(0);
    repeat (6) @(posedge clock);
    rd(RSS_REG_CLOSED, 32'h0, 32'h1 << ch[0]);
    rd(RSS_REG_CTRL, 32'h0, 32'h10);
    rq.push_back(32'h0);
    wr(RSS_REG_CTRL, 32'h14);
    settle();
    check({31'h0, scanning_ff}, 32'h0);
    // External source: abort has no effect, clear stops
    load_list();
    wr(RSS_REG_TRIG, 32'h3);
    rq.push_back(32'h1 << ch[0]);
    wr(RSS_REG_CTRL, 32'h3);
    settle();
    rq.push_back(32'h1 << ch[1]);
    host_u.fire_ext(3);
    settle();
    wr(RSS_REG_CTRL, 32'h5);
    repeat (4) @(posedge clock);
    check({31'h0, scanning_ff}, 32'h1);
    rq.push_back(32'h0);
    wr(RSS_REG_CTRL, 32'h9);
    settle();
    check({31'h0, scanning_ff}, 32'h0);
    final_report();
  end
endmodule
